// ---- include/hb_interp_pkg.sv ----
// Constants for the halfband interpolation chain.
// Assumes a single system clock; one output sample per clock at the converter rate.
// How it works
// - Stage one: 43-tap symmetric halfband, center 16384, neighbours 10364.
// - Stage three: 11-tap symmetric halfband, center 512, taps 7, -53, 302.
// - Every stage is a symmetric FIR, so group delay is a fixed count.
// - Chain raises sample rate by 1, 2, 4 or 8, attenuating images.
// - Optional complex mix by cos+j sin; both real and imaginary parts delivered.
// - Primary output code: all zeros is negative full scale, all ones is positive full scale.
// - Complementary output code is the bitwise inverse of the primary code.
package hb_interp_pkg;
  localparam int DW = 16;
  localparam int OW = 14;
  localparam int HB1_N = 11;
  localparam int HB2_N = 5;
  localparam int HB3_N = 3;
  localparam int HB1_SH = 15;
  localparam int HB2_SH = 14;
  localparam int HB3_SH = 10;
  localparam logic signed [17:0] HB1_CTR = 18'sd16384;
  localparam logic signed [17:0] HB2_CTR = 18'sd8192;
  localparam logic signed [17:0] HB3_CTR = 18'sd512;
  // Outer nonzero taps, edge inward; the zero taps are skipped entirely
  localparam logic signed [17:0] HB1_C [HB1_N] = '{18'sd8, -18'sd29, 18'sd67, -18'sd134, 18'sd244, -18'sd414,
    18'sd673, -18'sd1079, 18'sd1772, -18'sd3280, 18'sd10364};
  localparam logic signed [17:0] HB2_C [HB2_N] = '{18'sd19, -18'sd120, 18'sd438, -18'sd1288, 18'sd5047};
  localparam logic signed [17:0] HB3_C [HB3_N] = '{18'sd7, -18'sd53, 18'sd302};
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;
  localparam logic [1:0] RATE_8X = 2'h3;
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [1:0] MOD_FS2 = 2'h1;
  localparam logic [1:0] MOD_FS4 = 2'h2;
  localparam logic [1:0] MOD_FS8 = 2'h3;
  localparam logic signed [17:0] COS45 = 18'sd46341; // 0.7071 in Q16
  localparam int ROT_SH = 16;
  localparam logic [OW-1:0] MID_CODE = 14'h2000;
endpackage

// ---- hw/halfband_interpolation_chain.sv ----
// Halfband interpolation chain with complex mixer and complementary output codes.
// Assumes the source offers I/Q samples with in_valid/in_ready at up to the rate allowed
// by the selected interpolation; outputs advance one sample per clk_sys cycle.
`timescale 1ns/10ps

// One 2x halfband interpolator: polyphase, taking one input per two output slots.
module hb_stage
  import hb_interp_pkg::*;
#(
  parameter int N = 3,           // Nonzero outer taps per side
  parameter int SH = 10,         // Coefficient scale shift
  parameter logic signed [17:0] CTR = 18'sd512,
  parameter logic signed [17:0] C [N] = '{default: 18'sd0}
) (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic in_vld, // Input sample strobe
  input wire logic signed [DW-1:0] in_i, // Input I
  input wire logic signed [DW-1:0] in_q, // Input Q
  input wire logic out_take, // Output slot strobe
  output logic signed [DW-1:0] out_i_q, // Output I
  output logic signed [DW-1:0] out_q_q // Output Q
);
  localparam int L = 2 * N; // History length of the odd branch
  logic signed [DW-1:0] hi_q [L];
  logic signed [DW-1:0] hq_q [L];
  logic phase_q;
  logic signed [47:0] acc_i, acc_q;
  logic signed [DW-1:0] ctr_i_q, ctr_q_q;

  // Shift history on each input sample; fixed depth gives constant group delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int k = 0; k < L; k++) begin
        hi_q[k] <= '0;
        hq_q[k] <= '0;
      end
    end else if (in_vld) begin
      hi_q[0] <= in_i;
      hq_q[0] <= in_q;
      for (int k = 1; k < L; k++) begin
        hi_q[k] <= hi_q[k-1];
        hq_q[k] <= hq_q[k-1];
      end
    end
  end

  // Symmetric pre-add then multiply; only the nonzero taps cost hardware
  always_comb begin
    acc_i = '0;
    acc_q = '0;
    for (int k = 0; k < N; k++) begin
      acc_i = acc_i + 48'(C[k]) * (48'(hi_q[k]) + 48'(hi_q[L-1-k]));
      acc_q = acc_q + 48'(C[k]) * (48'(hq_q[k]) + 48'(hq_q[L-1-k]));
    end
  end

  // Center tap branch is a pure delay matched to the odd branch midpoint
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctr_i_q <= '0;
      ctr_q_q <= '0;
    end else begin
      ctr_i_q <= hi_q[N-1];
      ctr_q_q <= hq_q[N-1];
    end
  end

  // Alternate branches; the center branch multiplies by CTR (a power of two)
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
      out_i_q <= '0;
      out_q_q <= '0;
    end else if (out_take) begin
      phase_q <= ~phase_q;
      if (phase_q) begin
        out_i_q <= DW'((acc_i * 2) >>> SH);
        out_q_q <= DW'((acc_q * 2) >>> SH);
      end else begin
        out_i_q <= DW'((48'(ctr_i_q) * 48'(CTR) * 2) >>> SH);
        out_q_q <= DW'((48'(ctr_q_q) * 48'(CTR) * 2) >>> SH);
      end
    end
  end
endmodule // hb_stage

module halfband_interpolation_chain
  import hb_interp_pkg::*;
(
  input wire logic clk_sys, // 200 MHz converter clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [1:0] rate_sel, // Interpolation 1x/2x/4x/8x
  input wire logic [1:0] mod_sel, // Mixer none, fs/2, fs/4, fs/8
  input wire logic in_valid, // Source offers a sample
  output logic in_ready, // Sample taken this cycle
  input wire logic signed [DW-1:0] in_i, // I sample
  input wire logic signed [DW-1:0] in_q, // Q sample
  output logic [OW-1:0] primary_current_output_i_q, // I primary code
  output logic [OW-1:0] complementary_current_output_i_q, // I complementary code
  output logic [OW-1:0] primary_current_output_q_q, // Q primary code
  output logic [OW-1:0] complementary_current_output_q_q // Q complementary code
);
  logic [2:0] slot_q;
  logic take1, take2, take3, tick;
  logic signed [DW-1:0] s1i, s1q, s2i, s2q, s3i, s3q, xi, xq;
  logic signed [DW-1:0] ri, rq;
  logic [2:0] ph_q;
  logic signed [47:0] ai, aq;

  // Slot counter divides the output rate down to each stage's rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) slot_q <= '0;
    else slot_q <= slot_q + 3'h1;
  end

  // Stage one runs at the input-side rate; later stages at successively doubled rates
  always_comb begin
    take1 = 1'b0;
    take2 = 1'b0;
    take3 = 1'b0;
    tick = 1'b0;
    case (rate_sel)
      RATE_1X: tick = 1'b1;
      RATE_2X: begin
        take1 = 1'b1;
        tick = slot_q[0];
      end
      RATE_4X: begin
        take2 = 1'b1;
        take1 = slot_q[0];
        tick = &slot_q[1:0];
      end
      default: begin
        take3 = 1'b1;
        take2 = slot_q[0];
        take1 = &slot_q[1:0];
        tick = &slot_q;
      end
    endcase
  end

  // Source paced by the end of each input period; at 2x and above a missing sample repeats as zero-stuff free hold, at 1x in_i passes regardless of in_valid
  assign in_ready = tick;

  hb_stage #(.N(HB1_N), .SH(HB1_SH), .CTR(HB1_CTR), .C(HB1_C)) u_hb1 (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_vld(tick & in_valid), .in_i(in_i), .in_q(in_q),
    .out_take(take1), .out_i_q(s1i), .out_q_q(s1q));
  hb_stage #(.N(HB2_N), .SH(HB2_SH), .CTR(HB2_CTR), .C(HB2_C)) u_hb2 (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_vld(take1), .in_i(s1i), .in_q(s1q),
    .out_take(take2), .out_i_q(s2i), .out_q_q(s2q));
  hb_stage #(.N(HB3_N), .SH(HB3_SH), .CTR(HB3_CTR), .C(HB3_C)) u_hb3 (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_vld(take2), .in_i(s2i), .in_q(s2q),
    .out_take(take3), .out_i_q(s3i), .out_q_q(s3q));

  // Cascade order fixed: stage one first, stage three last
  always_comb begin
    case (rate_sel)
      RATE_1X: begin
        xi = in_i;
        xq = in_q;
      end
      RATE_2X: begin
        xi = s1i;
        xq = s1q;
      end
      RATE_4X: begin
        xi = s2i;
        xq = s2q;
      end
      default: begin
        xi = s3i;
        xq = s3q;
      end
    endcase
  end

  // Mixer phase advances once per output sample
  always_ff @(posedge clk_sys) begin
    if (sys_rst) ph_q <= '0;
    else ph_q <= ph_q + 3'h1;
  end

  // Rotation by e^{jwt}: step of pi, pi/2 or pi/4 per sample; 45-degree points use COS45
  always_comb begin
    ai = '0;
    aq = '0;
    ri = xi;
    rq = xq;
    case (mod_sel)
      MOD_NONE: begin
        ri = xi;
        rq = xq;
      end
      MOD_FS2: begin
        ri = ph_q[0] ? -xi : xi;
        rq = ph_q[0] ? -xq : xq;
      end
      MOD_FS4: begin
        case (ph_q[1:0])
          2'h0: begin ri = xi; rq = xq; end
          2'h1: begin ri = -xq; rq = xi; end
          2'h2: begin ri = -xi; rq = -xq; end
          default: begin ri = xq; rq = -xi; end
        endcase
      end
      default: begin
        // Odd phases sit at 45 degrees; rotate by the even neighbour then by 45
        ai = (48'(xi) - 48'(xq)) * 48'(COS45);
        aq = (48'(xi) + 48'(xq)) * 48'(COS45);
        case (ph_q)
          3'h0: begin ri = xi; rq = xq; end
          3'h2: begin ri = -xq; rq = xi; end
          3'h4: begin ri = -xi; rq = -xq; end
          3'h6: begin ri = xq; rq = -xi; end
          3'h1: begin ri = DW'(ai >>> ROT_SH); rq = DW'(aq >>> ROT_SH); end
          3'h3: begin ri = DW'(-(aq >>> ROT_SH)); rq = DW'(ai >>> ROT_SH); end
          3'h5: begin ri = DW'(-(ai >>> ROT_SH)); rq = DW'(-(aq >>> ROT_SH)); end
          default: begin ri = DW'(aq >>> ROT_SH); rq = DW'(-(ai >>> ROT_SH)); end
        endcase
      end
    endcase
  end

  // Offset binary: most negative maps to all zeros, most positive to all ones
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      primary_current_output_i_q <= MID_CODE;
      primary_current_output_q_q <= MID_CODE;
      complementary_current_output_i_q <= ~MID_CODE;
      complementary_current_output_q_q <= ~MID_CODE;
    end else begin
      primary_current_output_i_q <= ri[DW-1:DW-OW] ^ MID_CODE;
      primary_current_output_q_q <= rq[DW-1:DW-OW] ^ MID_CODE;
      complementary_current_output_i_q <= ~(ri[DW-1:DW-OW] ^ MID_CODE);
      complementary_current_output_q_q <= ~(rq[DW-1:DW-OW] ^ MID_CODE);
    end
  end
endmodule // halfband_interpolation_chain

// ---- testbench/hb_chain_properties.sv ----
// Port checks for the interpolation chain.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module hb_chain_checker
  import hb_interp_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [1:0] rate_sel, // Rate
  input wire logic [1:0] mod_sel, // Mixer
  input wire logic in_valid, // Offer
  input wire logic in_ready, // Take slot
  input wire logic signed [DW-1:0] in_i, // I in
  input wire logic signed [DW-1:0] in_q, // Q in
  input wire logic [OW-1:0] primary_current_output_i_q, // I code
  input wire logic [OW-1:0] complementary_current_output_i_q, // I inverse
  input wire logic [OW-1:0] primary_current_output_q_q, // Q code
  input wire logic [OW-1:0] complementary_current_output_q_q // Q inverse
);
  // Short aliases keep the properties readable
  wire [OW-1:0] pri_i = primary_current_output_i_q;
  wire [OW-1:0] pri_q = primary_current_output_q_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  inv_i_a: assert property (complementary_current_output_i_q == ~pri_i)
    else $error("I complement wrong");
  inv_q_a: assert property (complementary_current_output_q_q == ~pri_q)
    else $error("Q complement wrong");
  reset_mid_a: assert property ($fell(sys_rst) |-> pri_i == MID_CODE && pri_q == MID_CODE)
    else $error("Reset code wrong");
  ready_1x_a: assert property (rate_sel == RATE_1X |-> in_ready)
    else $error("1x slot missed");
  ready_2x_a: assert property (in_ready && rate_sel == RATE_2X |=> !in_ready ##1 in_ready)
    else $error("2x slot wrong");
  ready_4x_a: assert property (in_ready && rate_sel == RATE_4X |=> !in_ready [*3] ##1 in_ready)
    else $error("4x slot wrong");
  ready_8x_a: assert property (in_ready && rate_sel == RATE_8X |=> !in_ready [*7] ##1 in_ready)
    else $error("8x slot wrong");
  // Latency must be one cycle whatever the data
  pass_1x_a: assert property (rate_sel == RATE_1X && mod_sel == MOD_NONE && in_valid |=>
    pri_i == ($past(in_i[15:2]) ^ MID_CODE) && pri_q == ($past(in_q[15:2]) ^ MID_CODE))
    else $error("1x pass code wrong");
endmodule // hb_chain_checker

bind halfband_interpolation_chain hb_chain_checker u_chk (.*);

// ---- testbench/bb_source.sv ----
// Baseband source model: fixed levels, or random samples with gaps.
// Assumes the chain's take handshake.
`timescale 1ns/10ps
module bb_source
  import hb_interp_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic in_ready, // Take slot
  input wire logic rnd, // Random mode
  input wire logic signed [DW-1:0] lvl_i, // I level
  input wire logic signed [DW-1:0] lvl_q, // Q level
  output logic in_valid, // Offer
  output logic signed [DW-1:0] in_i, // I
  output logic signed [DW-1:0] in_q // Q
);
  logic [31:0] r;
  initial {in_valid, in_i, in_q} = '0;
  // Offer held until taken; each gap cycle inverts the data shown, so a two-cycle gap shows the stale sample again
  always @(posedge clk_sys) begin
    r = $urandom;
    if (sys_rst)
      in_valid <= 1'b0;
    else if (!in_valid || in_ready) begin
      in_valid <= !rnd || r[0];
      in_i <= !rnd ? lvl_i : r[0] ? r[31:16] : ~in_i;
      in_q <= !rnd ? lvl_q : r[0] ? r[15:0] : ~in_q;
    end
  end
endmodule // bb_source

// ---- testbench/tb_halfband_interpolation_chain.sv ----
// Self-checking bench for the interpolation chain.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/10ps
module tb_halfband_interpolation_chain
  import hb_interp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] rate_sel = 2'h0;
  logic [1:0] mod_sel = 2'h0;
  logic rnd = 1'b0;
  logic chk_on = 1'b0;
  logic signed [DW-1:0] lvl_i = 16'sh0;
  logic signed [DW-1:0] lvl_q = 16'sh0;
  logic in_valid, in_ready;
  logic signed [DW-1:0] in_i, in_q;
  logic [OW-1:0] p_i, c_i, p_q, c_q;
  logic [OW-1:0] a[9], b[9];
  logic [31:0] q[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int h;
  int j;
  int ex_v;
  logic [OW-1:0] imp[$];

  initial forever #2.5 clk_sys = ~clk_sys;

  halfband_interpolation_chain dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .rate_sel(rate_sel),
    .mod_sel(mod_sel), .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
    .primary_current_output_i_q(p_i), .complementary_current_output_i_q(c_i),
    .primary_current_output_q_q(p_q), .complementary_current_output_q_q(c_q));
  bb_source src (.clk_sys(clk_sys), .sys_rst(sys_rst), .in_ready(in_ready), .rnd(rnd),
    .lvl_i(lvl_i), .lvl_q(lvl_q), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

  // Signed value of an offset-binary code
  function automatic logic signed [15:0] sv(input logic [OW-1:0] c);
    return {{2{~c[13]}}, ~c[13], c[12:0]};
  endfunction

  // Code against an expected value; the tolerance absorbs filter rounding
  task automatic cmp(input logic [OW-1:0] got, input logic signed [15:0] ex, input int tol);
    logic signed [15:0] d;
    d = sv(got) - ex;
    n_tests++;
    if (((d <= tol) && (d >= -tol)) !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: code %h expected %0d", $time, got, ex);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Rate and mixer only change under reset
  task automatic restart(input logic [1:0] r, input logic [1:0] m);
    sys_rst <= 1'b1;
    rate_sel <= r;
    mod_sel <= m;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      close_out();
    end
  end

  // Model: at 1x with no mixing each take shows as the top 14 bits one cycle later
  always @(posedge clk_sys) begin
    if (chk_on && q.size() > 0) begin
      cmp(p_i, $signed(q[0][31:16]) >>> 2, 0);
      cmp(~c_i, $signed(q[0][31:16]) >>> 2, 0);
      cmp(p_q, $signed(q[0][15:0]) >>> 2, 0);
      cmp(~c_q, $signed(q[0][15:0]) >>> 2, 0);
      void'(q.pop_front());
    end
    if (chk_on && in_valid && in_ready)
      q.push_back({in_i, in_q});
  end

  initial begin
    void'($urandom(32'hFD635898));
    restart(RATE_1X, MOD_NONE);
    @(posedge clk_sys);
    cmp(p_i, 16'sh0, 0);
    cmp(~c_q, 16'sh0, 0);
    $display("test reset done");
    rnd <= 1'b1;
    chk_on <= 1'b1;
    repeat (80) @(posedge clk_sys);
    chk_on <= 1'b0;
    rnd <= 1'b0;
    $display("test stream done");
    // One full-scale sample through stage one at 2x: each odd tap shows once, the center midway
    lvl_q <= 16'sh0;
    restart(RATE_2X, MOD_NONE);
    lvl_i <= 16'sh8000;
    @(posedge clk_sys);
    lvl_i <= 16'sh0;
    repeat (60) begin
      @(posedge clk_sys);
      if (p_i != MID_CODE)
        imp.push_back(p_i);
    end
    for (int k = 0; k < 2 * HB1_N + 1; k++) begin
      j = (k <= HB1_N) ? k % HB1_N : 2 * HB1_N - k;
      // Odd taps give minus twice the tap; the center tap returns the sample itself
      ex_v = (k == HB1_N) ? -8192 : (-2 * int'(HB1_C[j])) >>> 2;
      cmp(k < imp.size() ? imp[k] : MID_CODE, 16'(ex_v), 0);
    end
    for (int k = 2 * HB1_N + 1; k < imp.size(); k++)
      cmp(imp[k], 16'sh0, 0);
    $display("test impulse done");
    // A held level must come through every rate at unity gain
    for (int r = 0; r < 4; r++) begin
      lvl_i <= 16'($urandom_range(16383)) - 16'h2000;
      lvl_q <= 16'($urandom_range(16383)) - 16'h2000;
      restart(2'(r), MOD_NONE);
      repeat (300) @(posedge clk_sys);
      cmp(p_i, lvl_i >>> 2, 2);
      cmp(p_q, lvl_q >>> 2, 2);
      $display("test rate %0d done", r);
    end
    // Half a mixer turn later both outputs must be negated
    for (int m = 1; m < 4; m++) begin
      restart(RATE_1X, 2'(m));
      repeat (20) @(posedge clk_sys);
      for (int k = 0; k < 9; k++) begin
        @(posedge clk_sys);
        a[k] = p_i;
        b[k] = p_q;
      end
      h = 1 << (m - 1);
      for (int k = 0; k + h < 9; k++) begin
        cmp(a[k + h], -sv(a[k]), 2);
        cmp(b[k + h], -sv(b[k]), 2);
        // A quarter turn moves minus the imaginary part to real and the real part to imaginary
        if (m > 1) begin
          cmp(a[k + h / 2], -sv(b[k]), 2);
          cmp(b[k + h / 2], sv(a[k]), 2);
        end
      end
      $display("test mixer %0d done", m);
    end
    close_out();
  end
endmodule // tb_halfband_interpolation_chain
